/* File: battery_charger_fuel_gauge_tb_top.sv */
// Self-checking bench for the charger and fuel gauge block
module battery_charger_fuel_gauge_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, avg_k = 16'h0000, r;
  logic vbus_k = 1'b1, full_k = 1'b0, sd_v_k = 1'b0, sd_up_k = 1'b0;
  logic [7:0] ratio_k = 8'hA0;
  logic [8:0] meas_k = 9'h000;
  logic vbus_present, vbat_target_reached, sd_bit_valid, sd_bit_up;
  logic [7:0] thermistor_ratio;
  logic [8:0] charge_current_meas;
  logic [15:0] avg_current_in;
  logic charger_enable, charger_cv_mode, current_divide_en, gauge_analog_en;
  logic [5:0] charge_current_setting, cur;
  logic [2:0] charge_voltage_select;
  logic [39:0] cnt;
  int err_count = 0, num_checks = 0, cycles = 0, nu, nd, v, m;
  logic [7:0] ratios [4] = '{8'h7F, 8'h80, 8'hE0, 8'hE1};
  bcfg_top #(.VBUS_LOW_CYCLES(20), .SAMPLE_DIV(10), .CNT_WIDTH(40)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .vbus_present(vbus_present), .thermistor_ratio(thermistor_ratio),
    .vbat_target_reached(vbat_target_reached),
    .charge_current_meas(charge_current_meas), .sd_bit_valid(sd_bit_valid),
    .sd_bit_up(sd_bit_up), .avg_current_in(avg_current_in),
    .charger_enable(charger_enable), .charger_cv_mode(charger_cv_mode),
    .charge_current_setting(charge_current_setting),
    .current_divide_en(current_divide_en),
    .charge_voltage_select(charge_voltage_select),
    .gauge_analog_en(gauge_analog_en));
  bcfg_battery_model u_batt (.clk(clk), .vbus_k(vbus_k), .ratio_k(ratio_k),
    .full_k(full_k), .meas_k(meas_k), .sd_v_k(sd_v_k), .sd_up_k(sd_up_k),
    .avg_k(avg_k), .vbus_present(vbus_present),
    .thermistor_ratio(thermistor_ratio),
    .vbat_target_reached(vbat_target_reached),
    .charge_current_meas(charge_current_meas), .sd_bit_valid(sd_bit_valid),
    .sd_bit_up(sd_bit_up), .avg_current_in(avg_current_in));
  initial begin
    forever #5 clk = ~clk;
  end
  // Hot limit binds even with cold protection off
  function automatic logic exp_en(logic [7:0] t, logic td, logic cd);
    return !(((t < 8'h80) && !td) || ((t > 8'hE0) && !td && !cd));
  endfunction
  function automatic logic exp_done(int ms, int st, logic cv);
    return cv && (ms * 10 <= st * 64);
  endfunction
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_cnt(input logic [39:0] g, input logic [39:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // The first part snapshots the whole count, so it is read first
  task automatic rd_cnt(output logic [39:0] c);
    logic [15:0] a, b, h;
    rd(4'h5, a);
    rd(4'h6, b);
    rd(4'h7, h);
    c = {h[7:0], b, a};
  endtask
  task automatic pulse(input logic up);
    sd_v_k = 1'b1;
    sd_up_k = up;
    @(negedge clk);
    sd_v_k = 1'b0;
    @(negedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    void'($urandom(46418));
    chk_bit(charger_enable, 1'b0);
    rd(4'h9, r);
    chk_reg(r, 16'h0000);
    for (int k = 0; k < 16; k++) begin
      cur = 6'($urandom_range(63, 1));
      ratio_k = ratios[k % 4];
      wr(4'h0, {7'h00, cur, k[3], k[2], 1'b1});
      idle(4);
      chk_bit(charger_enable, exp_en(ratio_k, k[2], k[3]));
      chk_reg(16'(charge_current_setting), 16'(cur));
      rd(4'h2, r);
      chk_bit(r[1], exp_en(ratio_k, k[2], k[3]));
    end
    ratio_k = 8'hA0;
    wr(4'h0, {7'h00, 6'h0A, 3'b001});
    idle(4);
    chk_bit(charger_cv_mode, 1'b0);
    full_k = 1'b1;
    idle(4);
    chk_bit(charger_cv_mode, 1'b1);
    for (int k = 0; k < 6; k++) begin
      meas_k = (k == 0) ? 9'd64 : (k == 1) ? 9'd65 : 9'($urandom_range(511));
      idle(4);
      rd(4'h2, r);
      chk_bit(r[2], exp_done(int'(meas_k), 10, 1'b1));
      chk_bit(charger_enable, 1'b1);
    end
    for (int c = 0; c < 16; c++) begin
      wr(4'h1, 16'(c));
      idle(2);
      chk_bit(current_divide_en, c == 6);
    end
    for (int c = 0; c < 8; c++) begin
      wr(4'h0, {4'h0, c[2:0], 6'h0A, 3'b001});
      idle(2);
      chk_reg(16'(charge_voltage_select), 16'(c));
    end
    vbus_k = 1'b0;
    idle(15);
    chk_bit(charger_enable, 1'b1);
    idle(10);
    chk_bit(charger_enable, 1'b0);
    vbus_k = 1'b1;
    idle(4);
    chk_bit(charger_enable, 1'b1);
    wr(4'h0, {7'h00, 6'h0A, 3'b000});
    idle(3);
    chk_bit(charger_enable, 1'b0);
    wr(4'h3, 16'h0001);
    nu = $urandom_range(40, 1);
    nd = $urandom_range(80, 1);
    repeat (nu) pulse(1'b1);
    repeat (nd) pulse(1'b0);
    idle(3);
    rd_cnt(cnt);
    chk_cnt(cnt, 40'(nu - nd));
    wr(4'h3, 16'h0001);
    idle(2);
    rd_cnt(cnt);
    chk_cnt(cnt, 40'h0000000000);
    v = $urandom_range(255, 1);
    wr(4'h4, 16'(v));
    wr(4'h3, 16'h0002);
    chk_bit(gauge_analog_en, 1'b0);
    idle(100);
    wr(4'h3, 16'h0000);
    rd_cnt(cnt);
    m = -int'(cnt[31:0]);
    chk_bit((m % v == 0) && m >= 9 * v && m <= 12 * v, 1'b1);
    chk_bit(gauge_analog_en, 1'b1);
    avg_k = 16'($urandom());
    idle(3);
    rd(4'h8, r);
    chk_reg(r, avg_k);
    conclude();
  end
endmodule

/* File: bcfg_battery_model.sv */
// Battery, thermistor and supply model on the analog side of the block
module bcfg_battery_model (
  // Clock
  input wire logic clk,
  // Scenario knobs from the bench
  input wire logic vbus_k,
  input wire logic [7:0] ratio_k,
  input wire logic full_k,
  input wire logic [8:0] meas_k,
  input wire logic sd_v_k,
  input wire logic sd_up_k,
  input wire logic [15:0] avg_k,
  // Analog side of the block
  output logic vbus_present,
  output logic [7:0] thermistor_ratio,
  output logic vbat_target_reached,
  output logic [8:0] charge_current_meas,
  output logic sd_bit_valid,
  output logic sd_bit_up,
  output logic [15:0] avg_current_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    vbus_present = 1'b1;
    thermistor_ratio = 8'hA0;
    vbat_target_reached = 1'b0;
    charge_current_meas = 9'h000;
    sd_bit_valid = 1'b0;
    sd_bit_up = 1'b0;
    avg_current_in = 16'h0000;
  end
  // Direction toggles between strobes so a stale value never counts
  always @(negedge clk) begin
    vbus_present <= vbus_k;
    thermistor_ratio <= ratio_k;
    vbat_target_reached <= full_k;
    charge_current_meas <= meas_k;
    sd_bit_valid <= sd_v_k;
    sd_bit_up <= sd_v_k ? sd_up_k : ~sd_bit_up;
    avg_current_in <= avg_k;
  end
endmodule

/* File: bcfg_consts.svh */
// Constants for the battery charger and fuel gauge control block
`ifndef BCFG_CONSTS_SVH
`define BCFG_CONSTS_SVH
`define BCFG_ADDR_CHG_CTRL1 4'h0
`define BCFG_ADDR_CHG_CTRL2 4'h1
`define BCFG_ADDR_CHG_STAT 4'h2
`define BCFG_ADDR_GAUGE_CTRL1 4'h3
`define BCFG_ADDR_ADD2CH 4'h4
`define BCFG_ADDR_CNTR1 4'h5
`define BCFG_ADDR_CNTR2 4'h6
`define BCFG_ADDR_CNTR3 4'h7
`define BCFG_ADDR_AVG 4'h8
// Control one fields
`define BCFG_C1_CHARGE_ON 0
`define BCFG_C1_THERM_DIS 1
`define BCFG_C1_COLD_DIS 2
`define BCFG_C1_CUR_LSB 3
`define BCFG_C1_CUR_MSB 8
`define BCFG_C1_VSEL_LSB 9
`define BCFG_C1_VSEL_MSB 11
`define BCFG_VSEL_CELL_TEST 3'h7
`define BCFG_TEST_DIVIDE 4'h6
// Status fields
`define BCFG_ST_ON 0
`define BCFG_ST_TEMP_OK 1
`define BCFG_ST_COMPLETE 2
`define BCFG_ST_CV 3
`define BCFG_ST_DIVIDE 4
`define BCFG_ST_VBUS_OK 5
// Gauge control fields
`define BCFG_G_RESET 0
`define BCFG_G_PSAVE 1
// Thermistor ratio limits in 1/8 units: below 4/8 hot, above 7/8 cold
`define BCFG_HOT_LIMIT 8'h80
`define BCFG_COLD_LIMIT 8'hE0
`define BCFG_VBUS_LOW_MS 10
`define BCFG_CLK_KHZ 100000
`define BCFG_SAMPLE_KHZ 1000
`define BCFG_CTRL1_RESET 16'h0000
`endif

/* File: bcfg_counter.sv */
// Forty-bit up/down charge counter with registered value
module bcfg_counter #(
  parameter int WIDTH = 40
) (
  input wire logic clk,
  input wire logic sys_rst,
  bcfg_ctr_if.ctr bus
);
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;

  // Two's complement, wraps modulo the width; clear wins over counting
  always_comb begin
    cnt_nxt = cnt_r;
    if (bus.clr) begin
      cnt_nxt = '0;
    end else if (bus.down) begin
      cnt_nxt = cnt_r - WIDTH'(bus.step);
    end else if (bus.up) begin
      cnt_nxt = cnt_r + WIDTH'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign bus.count = cnt_r;

  chk_clear_zeroes: assert property (@(posedge clk) disable iff (sys_rst)
    bus.clr |=> cnt_r == '0) else $error("counter not cleared");
  chk_count_up_one: assert property (@(posedge clk) disable iff (sys_rst)
    (!bus.clr && !bus.down && bus.up) |=> cnt_r == $past(cnt_r) + 1)
    else $error("counter did not step up");
  chk_psave_step: assert property (@(posedge clk) disable iff (sys_rst)
    (!bus.clr && bus.down) |=>
    cnt_r == $past(cnt_r) - WIDTH'($past(bus.step)))
    else $error("power save step wrong");
  cov_wrap_neg: cover property (@(posedge clk) cnt_r == '1);
endmodule

/* File: bcfg_ctr_if.sv */
// Signals between the control block and its charge counter
interface bcfg_ctr_if;
  logic clr;
  logic up;
  logic down;
  logic [15:0] step;
  logic [39:0] count;
  modport ctl(output clr, output up, output down, output step,
    input count);
  modport ctr(input clr, input up, input down, input step,
    output count);
endinterface

/* File: bcfg_pkg.sv */
// Types for the battery charger and fuel gauge control block
package bcfg_pkg;
  typedef enum logic [2:0] {
    BCFG_OFF = 3'b001,
    BCFG_CC = 3'b010,
    BCFG_CV = 3'b100
  } bcfg_mode_type;
endpackage

/* File: bcfg_top.sv */
// Battery charger control and coulomb-counting fuel gauge
`include "bcfg_consts.svh"
module bcfg_top #(
  parameter int VBUS_LOW_CYCLES =
    `BCFG_VBUS_LOW_MS * `BCFG_CLK_KHZ,
  parameter int SAMPLE_DIV = `BCFG_CLK_KHZ / `BCFG_SAMPLE_KHZ,
  parameter int CNT_WIDTH = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Peripheral register bus, 16 bits
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Analog sense inputs
  input wire logic vbus_present,
  input wire logic [7:0] thermistor_ratio,
  input wire logic vbat_target_reached,
  input wire logic [8:0] charge_current_meas,
  input wire logic sd_bit_valid,
  input wire logic sd_bit_up,
  input wire logic [15:0] avg_current_in,
  // Analog controls
  output logic charger_enable,
  output logic charger_cv_mode,
  output logic [5:0] charge_current_setting,
  output logic current_divide_en,
  output logic [2:0] charge_voltage_select,
  output logic gauge_analog_en
);
  localparam int VB_W = $clog2(VBUS_LOW_CYCLES + 1);
  localparam int SD_W = $clog2(SAMPLE_DIV + 1);

  // Register state
  logic [15:0] ctrl1_r, ctrl1_nxt;
  logic [3:0] test_r, test_nxt;
  logic [1:0] gctrl_r, gctrl_nxt;
  logic [15:0] add2ch_r, add2ch_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [15:0] avg_r;
  logic [39:0] snap_r, snap_nxt;
  // Charger state
  logic [VB_W-1:0] vb_cnt_r, vb_cnt_nxt;
  logic vbus_lost_r, vbus_lost_nxt;
  logic temp_ok_r, temp_ok_nxt;
  logic complete_r, complete_nxt;
  bcfg_pkg::bcfg_mode_type mode_r, mode_nxt;
  logic [SD_W-1:0] smp_r, smp_nxt;
  logic smp_tick;
  logic hot, cold, run_ok;

  bcfg_ctr_if ctr();

  bcfg_counter #(.WIDTH(CNT_WIDTH)) u_counter (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus(ctr)
  );

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  // Register writes and control
  always_comb begin
    ctrl1_nxt = ctrl1_r;
    test_nxt = test_r;
    gctrl_nxt = gctrl_r;
    add2ch_nxt = add2ch_r;
    if (reg_wr) begin
      if (hit(reg_addr, `BCFG_ADDR_CHG_CTRL1)) begin
        ctrl1_nxt = reg_wdata;
      end
      if (hit(reg_addr, `BCFG_ADDR_CHG_CTRL2)) begin
        test_nxt = reg_wdata[3:0];
      end
      if (hit(reg_addr, `BCFG_ADDR_ADD2CH)) begin
        add2ch_nxt = reg_wdata;
      end
      if (hit(reg_addr, `BCFG_ADDR_GAUGE_CTRL1)) begin
        gctrl_nxt = reg_wdata[1:0];
      end
    end
    // Counter reset bit is self-clearing after one cycle
    if (gctrl_r[`BCFG_G_RESET] &&
        !(reg_wr && hit(reg_addr, `BCFG_ADDR_GAUGE_CTRL1))) begin
      gctrl_nxt[`BCFG_G_RESET] = 1'b0;
    end
  end

  // Thermistor window, bus supply qualification, mode
  always_comb begin
    hot = thermistor_ratio < `BCFG_HOT_LIMIT;
    cold = (thermistor_ratio > `BCFG_COLD_LIMIT) &&
      !ctrl1_r[`BCFG_C1_COLD_DIS];
    // Disable bit removes the thermistor from charge control
    temp_ok_nxt = ctrl1_r[`BCFG_C1_THERM_DIS] || !(hot || cold);
    vb_cnt_nxt = vb_cnt_r;
    vbus_lost_nxt = vbus_lost_r;
    if (vbus_present) begin
      vb_cnt_nxt = '0;
      vbus_lost_nxt = 1'b0;
    end else if (vb_cnt_r >= VB_W'(VBUS_LOW_CYCLES)) begin
      vbus_lost_nxt = 1'b1;
    end else begin
      vb_cnt_nxt = vb_cnt_r + VB_W'(1);
    end
    run_ok = ctrl1_r[`BCFG_C1_CHARGE_ON] && !vbus_lost_r &&
      temp_ok_r;
    mode_nxt = mode_r;
    case (mode_r)
      bcfg_pkg::BCFG_OFF: if (run_ok) mode_nxt = bcfg_pkg::BCFG_CC;
      bcfg_pkg::BCFG_CC: begin
        if (!run_ok) mode_nxt = bcfg_pkg::BCFG_OFF;
        else if (vbat_target_reached) mode_nxt = bcfg_pkg::BCFG_CV;
      end
      bcfg_pkg::BCFG_CV: if (!run_ok) mode_nxt = bcfg_pkg::BCFG_OFF;
      default: mode_nxt = bcfg_pkg::BCFG_OFF;
    endcase
    // Flag only; the mode above never looks at it
    // Sixteen bits so that ten times the largest reading cannot wrap
    complete_nxt = (mode_r == bcfg_pkg::BCFG_CV) &&
      ({7'h00, charge_current_meas} * 16'h000A <=
       {10'h000, ctrl1_r[`BCFG_C1_CUR_MSB:`BCFG_C1_CUR_LSB]} *
       16'h0040);
  end

  // Power saving sample strobe at 1 MHz
  always_comb begin
    smp_tick = (smp_r == SD_W'(SAMPLE_DIV - 1));
    smp_nxt = smp_tick ? '0 : smp_r + SD_W'(1);
    ctr.clr = gctrl_r[`BCFG_G_RESET];
    // Discharge strobes step down by one; power save by the decrement
    ctr.down = gctrl_r[`BCFG_G_PSAVE] ? smp_tick :
      (sd_bit_valid && !sd_bit_up);
    ctr.up = !gctrl_r[`BCFG_G_PSAVE] && sd_bit_valid && sd_bit_up;
    ctr.step = gctrl_r[`BCFG_G_PSAVE] ? add2ch_r : 16'h0001;
  end

  // Read mux; counter is snapshotted on the low-part read
  always_comb begin
    rdata_nxt = rdata_r;
    snap_nxt = snap_r;
    if (reg_rd) begin
      case (reg_addr)
        `BCFG_ADDR_CHG_CTRL1: rdata_nxt = ctrl1_r;
        `BCFG_ADDR_CHG_CTRL2: rdata_nxt = {12'h000, test_r};
        `BCFG_ADDR_CHG_STAT: rdata_nxt = {10'h000, !vbus_lost_r,
          test_r == `BCFG_TEST_DIVIDE, mode_r == bcfg_pkg::BCFG_CV,
          complete_r, temp_ok_r, mode_r != bcfg_pkg::BCFG_OFF};
        `BCFG_ADDR_GAUGE_CTRL1: rdata_nxt = {14'h0000, gctrl_r};
        `BCFG_ADDR_ADD2CH: rdata_nxt = add2ch_r;
        `BCFG_ADDR_CNTR1: begin
          snap_nxt = ctr.count;
          rdata_nxt = ctr.count[15:0];
        end
        `BCFG_ADDR_CNTR2: rdata_nxt = snap_r[31:16];
        `BCFG_ADDR_CNTR3: rdata_nxt = {8'h00, snap_r[39:32]};
        `BCFG_ADDR_AVG: rdata_nxt = avg_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl1_r <= `BCFG_CTRL1_RESET;
      test_r <= '0;
      gctrl_r <= '0;
      add2ch_r <= '0;
      rdata_r <= '0;
      snap_r <= '0;
      avg_r <= '0;
      vb_cnt_r <= '0;
      vbus_lost_r <= 1'b1;
      temp_ok_r <= 1'b0;
      complete_r <= 1'b0;
      mode_r <= bcfg_pkg::BCFG_OFF;
      smp_r <= '0;
      charger_enable <= 1'b0;
      charger_cv_mode <= 1'b0;
      charge_current_setting <= '0;
      current_divide_en <= 1'b0;
      charge_voltage_select <= '0;
      gauge_analog_en <= 1'b0;
    end else begin
      ctrl1_r <= ctrl1_nxt;
      test_r <= test_nxt;
      gctrl_r <= gctrl_nxt;
      add2ch_r <= add2ch_nxt;
      rdata_r <= rdata_nxt;
      snap_r <= snap_nxt;
      avg_r <= avg_current_in;
      vb_cnt_r <= vb_cnt_nxt;
      vbus_lost_r <= vbus_lost_nxt;
      temp_ok_r <= temp_ok_nxt;
      complete_r <= complete_nxt;
      mode_r <= mode_nxt;
      smp_r <= smp_nxt;
      charger_enable <= mode_nxt != bcfg_pkg::BCFG_OFF;
      charger_cv_mode <= mode_nxt == bcfg_pkg::BCFG_CV;
      charge_current_setting <=
        ctrl1_nxt[`BCFG_C1_CUR_MSB:`BCFG_C1_CUR_LSB];
      current_divide_en <= test_nxt == `BCFG_TEST_DIVIDE;
      // Code 7 selects the 3.74 V cell-test level
      charge_voltage_select <=
        ctrl1_nxt[`BCFG_C1_VSEL_MSB:`BCFG_C1_VSEL_LSB];
      gauge_analog_en <= !gctrl_nxt[`BCFG_G_PSAVE];
    end
  end

  assign reg_rdata = rdata_r;

  chk_off_when_dis: assert property (@(posedge clk) disable iff (sys_rst)
    !ctrl1_r[`BCFG_C1_CHARGE_ON] |=> !charger_enable)
    else $error("charger on while bit clear");
  chk_vbus_loss: assert property (@(posedge clk) disable iff (sys_rst)
    vbus_lost_r |=> !charger_enable) else $error("on without vbus");
  chk_temp_hot: assert property (@(posedge clk) disable iff (sys_rst)
    (hot && !ctrl1_r[`BCFG_C1_THERM_DIS]) |=> !temp_ok_r ##1 !charger_enable)
    else $error("hot did not stop charging");
  chk_cv_after_cc: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(charger_cv_mode) |-> $past(mode_r == bcfg_pkg::BCFG_CC))
    else $error("cv without cc");
  chk_flag_no_stop: assert property (@(posedge clk) disable iff (sys_rst)
    (complete_r && run_ok && mode_r == bcfg_pkg::BCFG_CV) |=> charger_cv_mode)
    else $error("complete flag altered charge");
  chk_avg_read: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `BCFG_ADDR_AVG) |=> reg_rdata == $past(avg_r))
    else $error("average read wrong");
  cov_cc_cv: cover property (@(posedge clk) mode_r == bcfg_pkg::BCFG_CV);
  cov_complete: cover property (@(posedge clk) complete_r);
  cov_psave: cover property (@(posedge clk) ctr.down);
endmodule
